// ---- hdl/ticc_capture.v ----
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "ticc_defs.vh"

// What this block does
// R01: A qualifying pin event copies the selected 16-bit timer count.
// R02: Control bit 7 set takes the first timer, clear takes the second.
// R03: Mode 000 off, 001 both edges, 010 falling, 011 rising.
// R04: Mode 100 captures every 4th rising edge, 101 every 16th.
// R05: Mode 110 is unused and behaves as disabled.
// R06: Mode 111 is a rising-edge interrupt input only in sleep or idle.
// R07: Bits 6-5 give an interrupt after 1, 2, 3 or 4 captures.
// R08: In both-edges mode the captures-per-interrupt field is ignored.
// R09: Captures go into a four-word FIFO read out in order.
// R10: Bit 3 reads 1 while unread captures remain, cleared when empty.
// R11: Bit 4 shows capture overflow, is read-only and hardware-cleared.
// R12: Bit 13 set halts the channel in CPU idle, clear keeps it running.
// R13: Pin events can wake the device from sleep and idle.
// R14: Only channels one and two request DMA, each capture with field 00.
// R15: Control bits 15-14 and 12-8 always read zero.
// R16: Up to four independent channels, each with control, FIFO and pin.
// R17: A capture into a full FIFO is dropped and sets overflow until drained.
// R18: The pin is synchronised before edge detection, one event per edge.
module ticc_capture #(
	parameter NUM_CH     = 4,
	parameter FIFO_DEPTH = 4,
	parameter FIFO_PTR_W = 2,
	parameter ADDR_W     = 8
) (
	// Clock and reset
	input  wire              clk_sys,
	input  wire              reset_n,
	// AXI4-Lite write address
	input  wire [ADDR_W-1:0] s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output reg               s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output reg               s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	// AXI4-Lite read address
	input  wire [ADDR_W-1:0] s_axi_araddr,
	input  wire              s_axi_arvalid,
	output reg               s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	// Capture pins and time bases
	input  wire [NUM_CH-1:0] captureInputPin,
	input  wire [15:0]       firstTimerCount,
	input  wire [15:0]       secondTimerCount,
	// Power state
	input  wire              cpuIdle,
	input  wire              cpuSleep,
	// Events out
	output wire [NUM_CH-1:0] captureIrq,
	output wire [1:0]        dmaRequest,
	output reg               wakeRequest
);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function mapped;
		input [ADDR_W-1:0] addr;
		begin
			mapped = (addr[ADDR_W-1:`TICC_CH_STRIDE_LSB] < NUM_CH) &&
				((addr[3:0] == `TICC_OFS_CONTROL) || (addr[3:0] == `TICC_OFS_BUFFER));
		end
	endfunction

	function [ADDR_W-1:0] chanOf;
		input [ADDR_W-1:0] addr;
		begin
			chanOf = addr >> `TICC_CH_STRIDE_LSB;
		end
	endfunction

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	function prescaled;
		input [2:0] mode;
		begin
			prescaled = (mode == `TICC_MODE_RISE4) || (mode == `TICC_MODE_RISE16);
		end
	endfunction

	function wakeOnly;
		input [2:0] mode;
		begin
			wakeOnly = (mode == `TICC_MODE_WAKE);
		end
	endfunction

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	reg  [ADDR_W-1:0] awAddr_q;
	reg               awHeld_q;
	reg  [31:0]       wData_q;
	reg  [3:0]        wStrb_q;
	reg               wHeld_q;
	wire              writeGo;
	wire              awTake;
	wire              wTake;

	assign awTake  = s_axi_awvalid & s_axi_awready;
	assign wTake   = s_axi_wvalid & s_axi_wready;
	assign writeGo = awHeld_q & wHeld_q & ~s_axi_bvalid;

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			awAddr_q      <= {ADDR_W{1'b0}};
			awHeld_q      <= 1'b0;
			wData_q       <= 32'h0000_0000;
			wStrb_q       <= 4'h0;
			wHeld_q       <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `TICC_RESP_OKAY;
		end else begin
			if (awTake) begin
				awAddr_q <= s_axi_awaddr;
				awHeld_q <= 1'b1;
			end else if (writeGo) begin
				awHeld_q <= 1'b0;
			end
			if (wTake) begin
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
				wHeld_q <= 1'b1;
			end else if (writeGo) begin
				wHeld_q <= 1'b0;
			end
			// Ready only while the holding slot is free
			s_axi_awready <= ~awHeld_q & ~awTake & ~s_axi_awready;
			s_axi_wready  <= ~wHeld_q & ~wTake & ~s_axi_wready;
			if (writeGo) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped(awAddr_q) ? `TICC_RESP_OKAY : `TICC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	wire              arTake;
	wire [ADDR_W-1:0] arChan;
	wire [NUM_CH*16-1:0] ctrlView;
	wire [NUM_CH*16-1:0] headView;

	assign arTake = s_axi_arvalid & s_axi_arready;
	assign arChan = chanOf(s_axi_araddr);

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `TICC_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~arTake & ~s_axi_arready;
			if (arTake) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= 32'h0000_0000;
				s_axi_rresp  <= `TICC_RESP_SLVERR;
				if (mapped(s_axi_araddr)) begin
					s_axi_rresp <= `TICC_RESP_OKAY;
					if (s_axi_araddr[3:0] == `TICC_OFS_CONTROL) begin
						s_axi_rdata <= {16'h0000, ctrlView[arChan[1:0]*16 +: 16]};
					end else begin
						// Empty buffer reads as zero and pops nothing
						s_axi_rdata <= {16'h0000, headView[arChan[1:0]*16 +: 16]};
					end
				end
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Capture channels
	// ----------------------------------------
	wire [NUM_CH-1:0] wakeEvt;
	wire [NUM_CH-1:0] dmaPulse;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g = g + 1) begin : gCh
			reg  [2:0]  mode_q;
			reg         timeBase_q;
			reg  [1:0]  perIrq_q;
			reg         idleStop_q;
			reg         ovf_q;
			reg  [2:0]  sync_q;
			reg  [3:0]  pre_q;
			reg  [1:0]  irqCnt_q;
			reg         irq_q;
			reg         dma_q;
			reg         evt;
			reg         preHit;
			wire        rise;
			wire        fall;
			wire        running;
			wire        ctrlWr;
			wire        popReq;
			wire        wrReady;
			wire        rdValid;
			wire [15:0] rdData;
			wire [15:0] stamp;
			wire        irqNow;

			assign ctrlWr  = writeGo && mapped(awAddr_q) && (chanOf(awAddr_q) == g) &&
				(awAddr_q[3:0] == `TICC_OFS_CONTROL);
			assign popReq  = arTake && mapped(s_axi_araddr) && (arChan == g) &&
				(s_axi_araddr[3:0] == `TICC_OFS_BUFFER);
			// Bit 1 and bit 2 of the chain form the edge detector
			assign rise    = sync_q[1] & ~sync_q[2]; // [R18]
			assign fall    = ~sync_q[1] & sync_q[2]; // [R18]
			assign running = ~cpuSleep & ~(idleStop_q & cpuIdle); // [R12]
			assign stamp   = timeBase_q ? firstTimerCount : secondTimerCount; // [R01] [R02]

			always @* begin
				preHit = 1'b0;
				evt    = 1'b0;
				case (mode_q)
					`TICC_MODE_BOTH: evt = rise | fall; // [R03]
					`TICC_MODE_FALL: evt = fall; // [R03]
					`TICC_MODE_RISE: evt = rise; // [R03]
					`TICC_MODE_RISE4: begin
						preHit = (pre_q == `TICC_PRE4_LAST);
						evt    = rise & preHit; // [R04]
					end
					`TICC_MODE_RISE16: begin
						preHit = (pre_q == `TICC_PRE16_LAST);
						evt    = rise & preHit; // [R04]
					end
					default: evt = 1'b0; // [R03] [R05] [R06]
				endcase
				evt = evt & running;
			end

			assign irqNow = (mode_q == `TICC_MODE_BOTH) | (irqCnt_q == perIrq_q); // [R07] [R08]

			// In sleep or idle, wake on any capture event or on a rising edge in interrupt-only mode
			assign wakeEvt[g] = (cpuSleep | cpuIdle) & ((wakeOnly(mode_q) & rise) | evt); // [R13]

			always @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					mode_q     <= `TICC_MODE_OFF;
					timeBase_q <= 1'b0;
					perIrq_q   <= 2'h0;
					idleStop_q <= 1'b0;
					ovf_q      <= 1'b0;
					sync_q     <= 3'h0;
					pre_q      <= 4'h0;
					irqCnt_q   <= 2'h0;
					irq_q      <= 1'b0;
					dma_q      <= 1'b0;
				end else begin
					sync_q <= {sync_q[1:0], captureInputPin[g]}; // [R18]
					irq_q  <= 1'b0;
					dma_q  <= 1'b0;
					if (ctrlWr && wStrb_q[0]) begin
						mode_q     <= wData_q[`TICC_MODE_MSB:`TICC_MODE_LSB];
						perIrq_q   <= wData_q[`TICC_CPI_MSB:`TICC_CPI_LSB];
						timeBase_q <= wData_q[`TICC_TIME_BASE_BIT];
						// New setup restarts prescaler and capture count
						pre_q      <= 4'h0;
						irqCnt_q   <= 2'h0;
					end else begin
						if (rise && running && prescaled(mode_q)) begin
							pre_q <= preHit ? 4'h0 : pre_q + 4'h1; // [R04]
						end
						if (evt) begin
							irqCnt_q <= irqNow ? 2'h0 : irqCnt_q + 2'h1; // [R07]
							irq_q    <= irqNow; // [R07] [R08]
							dma_q    <= (perIrq_q == 2'h0); // [R14]
						end else if (wakeOnly(mode_q) && rise && (cpuSleep || cpuIdle)) begin
							irq_q <= 1'b1; // [R06]
						end
					end
					if (ctrlWr && wStrb_q[1]) begin
						idleStop_q <= wData_q[`TICC_IDLE_STOP_BIT]; // [R12]
					end
					// Set wins over the drain clear
					if (evt && !wrReady) begin
						ovf_q <= 1'b1; // [R11] [R17]
					end else if (!rdValid) begin
						ovf_q <= 1'b0; // [R11] [R17]
					end
				end
			end

			// Full FIFO holds off the write; the value is dropped
			ticc_fifo #(
				.WIDTH (16),
				.DEPTH (FIFO_DEPTH),
				.PTR_W (FIFO_PTR_W)
			) uFifo (
				.clk_sys (clk_sys),
				.reset_n (reset_n),
				.wrValid (evt), // [R09] [R17]
				.wrReady (wrReady),
				.wrData  (stamp),
				.rdValid (rdValid),
				.rdReady (popReq), // [R09]
				.rdData  (rdData)
			);

			assign headView[g*16 +: 16] = rdValid ? rdData : 16'h0000;
			assign ctrlView[g*16 +: 16] = {2'h0, idleStop_q, 5'h00, timeBase_q, perIrq_q, // [R15]
				ovf_q, rdValid, mode_q}; // [R10] [R11]
			assign captureIrq[g]        = irq_q; // [R16]
			assign dmaPulse[g]          = dma_q;
		end
	endgenerate

	// ----------------------------------------
	// DMA and wake outputs
	// ----------------------------------------
	// Channels above the second never reach DMA
	assign dmaRequest = {dmaPulse[1], dmaPulse[0]}; // [R14]

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wakeRequest <= 1'b0;
		end else begin
			wakeRequest <= |wakeEvt; // [R13]
		end
	end

endmodule

// ---- hdl/ticc_defs.vh ----
`ifndef TICC_DEFS_VH
`define TICC_DEFS_VH

// ----------------------------------------
// Register map, one 16-byte window per channel
// ----------------------------------------
`define TICC_CH_STRIDE_LSB   4
`define TICC_OFS_CONTROL     4'h0
`define TICC_OFS_BUFFER      4'h4

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define TICC_IDLE_STOP_BIT   13
`define TICC_TIME_BASE_BIT   7
`define TICC_CPI_MSB         6
`define TICC_CPI_LSB         5
`define TICC_OVF_BIT         4
`define TICC_BNE_BIT         3
`define TICC_MODE_MSB        2
`define TICC_MODE_LSB        0
`define TICC_CTRL_RESET      16'h0000

// ----------------------------------------
// Capture modes
// ----------------------------------------
`define TICC_MODE_OFF        3'h0
`define TICC_MODE_BOTH       3'h1
`define TICC_MODE_FALL       3'h2
`define TICC_MODE_RISE       3'h3
`define TICC_MODE_RISE4      3'h4
`define TICC_MODE_RISE16     3'h5
`define TICC_MODE_UNUSED     3'h6
`define TICC_MODE_WAKE       3'h7

// ----------------------------------------
// Prescaler terminal counts
// ----------------------------------------
`define TICC_PRE4_LAST       4'h3
`define TICC_PRE16_LAST      4'hF

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define TICC_RESP_OKAY       2'h0
`define TICC_RESP_SLVERR     2'h2

`endif

// ---- hdl/ticc_fifo.v ----
`timescale 1ns/10ps
module ticc_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 4,
	parameter PTR_W = 2
) (
	// Clock and reset
	input  wire             clk_sys,
	input  wire             reset_n,
	// Fill side
	input  wire             wrValid,
	output wire             wrReady,
	input  wire [WIDTH-1:0] wrData,
	// Drain side
	output wire             rdValid,
	input  wire             rdReady,
	output wire [WIDTH-1:0] rdData
);

	// ----------------------------------------
	// Storage and pointers
	// ----------------------------------------
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [PTR_W-1:0] wrPtr_q;
	reg [PTR_W-1:0] rdPtr_q;
	reg [PTR_W:0]   count_q;
	localparam [PTR_W:0] FULL_CNT = DEPTH;
	wire            doPush;
	wire            doPop;
	integer         i;

	assign wrReady = (count_q != FULL_CNT);
	assign rdValid = (count_q != {(PTR_W+1){1'b0}});
	assign rdData  = mem_q[rdPtr_q];
	assign doPush  = wrValid & wrReady;
	assign doPop   = rdValid & rdReady;

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wrPtr_q <= {PTR_W{1'b0}};
			rdPtr_q <= {PTR_W{1'b0}};
			count_q <= {(PTR_W+1){1'b0}};
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem_q[i] <= {WIDTH{1'b0}};
			end
		end else begin
			if (doPush) begin
				mem_q[wrPtr_q] <= wrData;
				// Depth is a power of two, pointers wrap naturally
				wrPtr_q        <= wrPtr_q + 1'b1;
			end
			if (doPop) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
			if (doPush && !doPop) begin
				count_q <= count_q + 1'b1;
			end else if (doPop && !doPush) begin
				count_q <= count_q - 1'b1;
			end
		end
	end

endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
	logic        clk_sys = 0, reset_n = 0, pin0, wakeRequest, cpuIdle = 0, cpuSleep = 0;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, dmaRequest, rr, br;
	logic [3:0]  captureIrq;
	logic [15:0] firstTimerCount = 0, secondTimerCount = 0, rd;
	int          error_cnt = 0, num_checks = 0, cycles = 0, irqCnt = 0, dmaCnt = 0, wakeCnt = 0, otherCnt = 0;
	int          expCap[7] = '{0, 32, 16, 16, 4, 1, 0};
	always #2 clk_sys = ~clk_sys;
	ticc_pin_model u_pin (.clk_sys(clk_sys), .pinOut(pin0));
	ticc_capture u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .captureInputPin({3'b000, pin0}), .firstTimerCount(firstTimerCount),
		.secondTimerCount(secondTimerCount), .cpuIdle(cpuIdle), .cpuSleep(cpuSleep),
		.captureIrq(captureIrq), .dmaRequest(dmaRequest), .wakeRequest(wakeRequest));
	// ----
	// Event counters and hang guard
	// ----
	always @(posedge clk_sys) begin
		cycles++;
		if (captureIrq[0] === 1'b1) irqCnt++;
		if (dmaRequest[0] === 1'b1) dmaCnt++;
		if (wakeRequest === 1'b1) wakeCnt++;
		// Idle channels must stay silent
		if (captureIrq[3:1] !== 3'b000 || dmaRequest[1] !== 1'b0) otherCnt++;
		if (cycles == 30000) begin
			error_cnt++;
			summarize();
		end
	end
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// ----
	// Bus tasks; each starts on a fresh edge so no signal is driven twice
	// ----
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'b1);
		br = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task rdr(input logic [7:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata[15:0];
		rr = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	task edges(input int n);
		u_pin.toggle(n);
		repeat (8) @(posedge clk_sys);
	endtask
	task clr;
		irqCnt = 0;
		dmaCnt = 0;
		wakeCnt = 0;
	endtask
	// ----
	// Tests
	// ----
	initial begin
		repeat (4) @(posedge clk_sys);
		reset_n <= 1;
		rdr(8'h00); check("ctrl reset", rd, 16'h0000);
		rdr(8'h80); check("unmapped resp", rr, 2'h2);
		wr(8'h80, 16'h0001); check("unmapped write", br, 2'h2);
		wr(8'h00, 16'hFFFF); rdr(8'h00); check("ctrl bits", rd, 16'h20E7);
		check("write resp", br, 2'h0);
		rdr(8'h10); check("ch1 apart", rd, 16'h0000);
		$display("test registers done");
		for (int m = 0; m < 7; m++) begin
			wr(8'h00, 16'h0080 | 16'(m));
			clr();
			edges(32);
			check("mode captures", irqCnt, expCap[m]);
			check("dma captures", dmaCnt, expCap[m]);
			rdr(8'h00); check("overflow", rd[4], expCap[m] > 4);
			repeat (4) rdr(8'h04);
			rdr(8'h00); check("drained flags", rd[4:3], 2'b00);
		end
		$display("test modes done");
		wr(8'h00, 16'h0083);
		for (int k = 0; k < 3; k++) begin
			if (k == 2) wr(8'h00, 16'h0003);
			firstTimerCount <= 16'(16'h1000 + k);
			secondTimerCount <= 16'(16'h2000 + k);
			edges(2);
		end
		rdr(8'h00); check("not empty", rd[3], 1);
		for (int k = 0; k < 3; k++) begin
			rdr(8'h04); check("fifo order", rd, k == 2 ? 16'h2002 : 16'(16'h1000 + k));
		end
		rdr(8'h04); check("empty read", rd, 16'h0000);
		$display("test fifo done");
		for (int c = 1; c < 4; c++) begin
			wr(8'h00, 16'h0083 | 16'(c << 5));
			clr();
			edges(4 * (c + 1));
			check("irq per group", irqCnt, 2);
		end
		wr(8'h00, 16'h0061); clr(); edges(4); check("both edges", irqCnt, 4);
		$display("test interrupt rate done");
		cpuIdle <= 1;
		wr(8'h00, 16'h2083); clr(); edges(4); check("idle halt", irqCnt, 0);
		wr(8'h00, 16'h0083); clr(); edges(4); check("idle run", irqCnt, 2);
		check("idle wake", wakeCnt, 2);
		cpuIdle <= 0;
		cpuSleep <= 1;
		wr(8'h00, 16'h0007); clr(); edges(4); check("sleep irq", irqCnt, 2);
		check("sleep wake", wakeCnt, 2);
		cpuSleep <= 0;
		clr(); edges(4); check("awake irq", irqCnt, 0);
		check("other channels", otherCnt, 0);
		$display("test power done");
		summarize();
	end
endmodule

// ---- test/ticc_assertions.sv ----
`timescale 1ns/10ps
module ticc_checker #(
	parameter NUM_CH = 4
) (
	// Clock and reset
	input logic              clk_sys,
	input logic              reset_n,
	// Bus answers
	input logic              s_axi_bvalid,
	input logic              s_axi_bready,
	input logic [1:0]        s_axi_bresp,
	input logic              s_axi_arvalid,
	input logic              s_axi_arready,
	input logic              s_axi_rvalid,
	input logic              s_axi_rready,
	input logic [1:0]        s_axi_rresp,
	input logic [31:0]       s_axi_rdata,
	// Events and power
	input logic [NUM_CH-1:0] captureIrq,
	input logic [1:0]        dmaRequest,
	input logic              wakeRequest,
	input logic              cpuIdle,
	input logic              cpuSleep
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	property p_readAnswer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_readAnswer: assert property (p_readAnswer) else $error("read not answered");
	property p_rdataHold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rdataHold: assert property (p_rdataHold) else $error("read data dropped");
	property p_upperZero;
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
	endproperty
	a_upperZero: assert property (p_upperZero) else $error("upper read bits set");
	property p_errZero;
		s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0000_0000;
	endproperty
	a_errZero: assert property (p_errZero) else $error("error read not zero");
	property p_bHold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bHold: assert property (p_bHold) else $error("write answer dropped");
	property p_irqPulse;
		captureIrq[0] |=> !captureIrq[0];
	endproperty
	a_irqPulse: assert property (p_irqPulse) else $error("irq longer than a pulse");
	property p_dmaIrq;
		dmaRequest[0] |-> captureIrq[0];
	endproperty
	a_dmaIrq: assert property (p_dmaIrq) else $error("dma without capture");
	property p_wakeLow;
		wakeRequest |-> $past(cpuIdle || cpuSleep);
	endproperty
	a_wakeLow: assert property (p_wakeLow) else $error("wake while running");
endmodule

bind ticc_capture ticc_checker #(.NUM_CH(NUM_CH)) u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata),
	.captureIrq(captureIrq), .dmaRequest(dmaRequest), .wakeRequest(wakeRequest),
	.cpuIdle(cpuIdle), .cpuSleep(cpuSleep));

// ---- test/ticc_pin_model.sv ----
`timescale 1ns/10ps
module ticc_pin_model (
	// Clock and pin
	input  logic clk_sys,
	output logic pinOut
);
	initial pinOut = 1'b0;
	// Edges six cycles apart, slower than the synchroniser
	task automatic toggle(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			pinOut <= ~pinOut;
			repeat (5) @(posedge clk_sys);
		end
	endtask
endmodule
